// ==== core/sad_pkg.sv ====
package sad_pkg;

   // ****************************************
   // Region map
   // ****************************************
   localparam logic [31:0] FLASH_BASE = 32'h0000_0000;
   localparam logic [31:0] FLASH_LAST_512K = 32'h0007_FFFF;
   localparam logic [31:0] FLASH_LAST_256K = 32'h0003_FFFF;
   localparam logic [31:0] FLASH_LAST_128K = 32'h0001_FFFF;
   localparam logic [31:0] FLASH_LAST_64K = 32'h0000_FFFF;
   localparam logic [31:0] SRAM_BASE = 32'h1000_0000;
   localparam logic [31:0] SRAM_LAST_64K = 32'h1000_FFFF;
   localparam logic [31:0] SRAM_LAST_32K = 32'h1000_7FFF;
   localparam logic [31:0] SRAM_LAST_16K = 32'h1000_3FFF;
   localparam logic [31:0] BOOT_BASE = 32'h1FFF_0000;
   localparam logic [31:0] BOOT_LAST = 32'h1FFF_1FFF;
   localparam logic [31:0] PSRAM0_BASE = 32'h2000_0000;
   localparam logic [31:0] PSRAM0_LAST = 32'h2000_3FFF;
   localparam logic [31:0] PSRAM1_BASE = 32'h2000_4000;
   localparam logic [31:0] PSRAM1_LAST = 32'h2000_7FFF;
   localparam logic [31:0] HSP_BASE = 32'h2008_0000;
   localparam logic [31:0] HSP_LAST = 32'h200B_FFFF;
   localparam logic [31:0] LSB0_BASE = 32'h4000_0000;
   localparam logic [31:0] LSB0_LAST = 32'h4007_FFFF;
   localparam logic [31:0] LSB1_BASE = 32'h4008_0000;
   localparam logic [31:0] LSB1_LAST = 32'h400F_FFFF;
   localparam logic [31:0] SCS0_BASE = 32'h8000_0000;
   localparam logic [31:0] SCS0_LAST = 32'h83FF_FFFF;
   localparam logic [31:0] SCS1_BASE = 32'h9000_0000;
   localparam logic [31:0] SCS1_LAST = 32'h93FF_FFFF;
   localparam logic [31:0] SCS2_BASE = 32'h9800_0000;
   localparam logic [31:0] SCS2_LAST = 32'h9BFF_FFFF;
   localparam logic [31:0] SCS3_BASE = 32'h9C00_0000;
   localparam logic [31:0] SCS3_LAST = 32'h9FFF_FFFF;
   localparam logic [31:0] DCS0_BASE = 32'hA000_0000;
   localparam logic [31:0] DCS0_LAST = 32'hAFFF_FFFF;
   localparam logic [31:0] DCS1_BASE = 32'hB000_0000;
   localparam logic [31:0] DCS1_LAST = 32'hBFFF_FFFF;
   localparam logic [31:0] DCS2_BASE = 32'hC000_0000;
   localparam logic [31:0] DCS2_LAST = 32'hCFFF_FFFF;
   localparam logic [31:0] DCS3_BASE = 32'hD000_0000;
   localparam logic [31:0] DCS3_LAST = 32'hDFFF_FFFF;
   localparam logic [31:0] PPB_BASE = 32'hE000_0000;
   localparam logic [31:0] PPB_LAST = 32'hE00F_FFFF;

   // ****************************************
   // Vector remap and slot geometry
   // ****************************************
   localparam logic [31:0] VEC_LAST = 32'h0000_003F;
   localparam int SLOT_LSB = 14;
   localparam int HSP_SLOTS = 128;
   localparam int LSP_SLOTS = 64;
   localparam int LSB_SLOTS = 32;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {SAD_SZ_LARGE, SAD_SZ_HALF, SAD_SZ_QUARTER, SAD_SZ_EIGHTH} sad_size_e;
   typedef enum logic [1:0] {SAD_REMAP_NONE, SAD_REMAP_BOOT, SAD_REMAP_SRAM,
                             SAD_REMAP_PSRAM} sad_remap_e;

   typedef enum logic [4:0] {
      SAD_T_NONE, SAD_T_FLASH, SAD_T_SRAM, SAD_T_BOOT, SAD_T_PSRAM0, SAD_T_PSRAM1,
      SAD_T_HSP, SAD_T_LSB0, SAD_T_LSB1, SAD_T_SCS0, SAD_T_SCS1, SAD_T_SCS2,
      SAD_T_SCS3, SAD_T_DCS0, SAD_T_DCS1, SAD_T_DCS2, SAD_T_DCS3, SAD_T_PPB
   } sad_target_e;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
   } sad_req_s;

   typedef struct packed {
      sad_target_e target;
      logic [31:0] addr;
      logic [6:0] slot;
      logic error;
   } sad_route_s;

   function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                     input logic [31:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

endpackage

// ==== core/sad_region_decode.sv ====
`timescale 1ns/1ps
module sad_region_decode
(
   input wire logic [31:0] addr,
   input wire sad_pkg::sad_size_e flash_size,
   input wire sad_pkg::sad_size_e sram_size,
   output sad_pkg::sad_target_e target
);

   logic [31:0] flash_last;
   logic [31:0] sram_last;

   always_comb
   begin
      case (flash_size)
         sad_pkg::SAD_SZ_LARGE: flash_last = sad_pkg::FLASH_LAST_512K;
         sad_pkg::SAD_SZ_HALF: flash_last = sad_pkg::FLASH_LAST_256K;
         sad_pkg::SAD_SZ_QUARTER: flash_last = sad_pkg::FLASH_LAST_128K;
         default: flash_last = sad_pkg::FLASH_LAST_64K;
      endcase
      case (sram_size)
         sad_pkg::SAD_SZ_LARGE: sram_last = sad_pkg::SRAM_LAST_64K;
         sad_pkg::SAD_SZ_HALF: sram_last = sad_pkg::SRAM_LAST_32K;
         default: sram_last = sad_pkg::SRAM_LAST_16K;
      endcase
   end

   // Ranges are disjoint, so order only matters for readability
   always_comb
   begin
      target = sad_pkg::SAD_T_NONE; // see RQ23
      if (sad_pkg::in_range(addr, sad_pkg::FLASH_BASE, flash_last))
         target = sad_pkg::SAD_T_FLASH; // see RQ1
      else if (sad_pkg::in_range(addr, sad_pkg::SRAM_BASE, sram_last))
         target = sad_pkg::SAD_T_SRAM; // see RQ2
      else if (sad_pkg::in_range(addr, sad_pkg::BOOT_BASE, sad_pkg::BOOT_LAST))
         target = sad_pkg::SAD_T_BOOT; // see RQ3
      else if (sad_pkg::in_range(addr, sad_pkg::PSRAM0_BASE, sad_pkg::PSRAM0_LAST))
         target = sad_pkg::SAD_T_PSRAM0; // see RQ4
      else if (sad_pkg::in_range(addr, sad_pkg::PSRAM1_BASE, sad_pkg::PSRAM1_LAST))
         target = sad_pkg::SAD_T_PSRAM1; // see RQ5
      else if (sad_pkg::in_range(addr, sad_pkg::HSP_BASE, sad_pkg::HSP_LAST))
         target = sad_pkg::SAD_T_HSP; // see RQ6
      else if (sad_pkg::in_range(addr, sad_pkg::LSB0_BASE, sad_pkg::LSB0_LAST))
         target = sad_pkg::SAD_T_LSB0; // see RQ8
      else if (sad_pkg::in_range(addr, sad_pkg::LSB1_BASE, sad_pkg::LSB1_LAST))
         target = sad_pkg::SAD_T_LSB1; // see RQ9
      else if (sad_pkg::in_range(addr, sad_pkg::SCS0_BASE, sad_pkg::SCS0_LAST))
         target = sad_pkg::SAD_T_SCS0; // see RQ12
      else if (sad_pkg::in_range(addr, sad_pkg::SCS1_BASE, sad_pkg::SCS1_LAST))
         target = sad_pkg::SAD_T_SCS1; // see RQ13
      else if (sad_pkg::in_range(addr, sad_pkg::SCS2_BASE, sad_pkg::SCS2_LAST))
         target = sad_pkg::SAD_T_SCS2; // see RQ14
      else if (sad_pkg::in_range(addr, sad_pkg::SCS3_BASE, sad_pkg::SCS3_LAST))
         target = sad_pkg::SAD_T_SCS3; // see RQ15
      else if (sad_pkg::in_range(addr, sad_pkg::DCS0_BASE, sad_pkg::DCS0_LAST))
         target = sad_pkg::SAD_T_DCS0; // see RQ16
      else if (sad_pkg::in_range(addr, sad_pkg::DCS1_BASE, sad_pkg::DCS1_LAST))
         target = sad_pkg::SAD_T_DCS1; // see RQ17
      else if (sad_pkg::in_range(addr, sad_pkg::DCS2_BASE, sad_pkg::DCS2_LAST))
         target = sad_pkg::SAD_T_DCS2; // see RQ18
      else if (sad_pkg::in_range(addr, sad_pkg::DCS3_BASE, sad_pkg::DCS3_LAST))
         target = sad_pkg::SAD_T_DCS3; // see RQ19
      else if (sad_pkg::in_range(addr, sad_pkg::PPB_BASE, sad_pkg::PPB_LAST))
         target = sad_pkg::SAD_T_PPB; // see RQ20
   end

endmodule

// ==== core/sad_master_port.sv ====
`timescale 1ns/1ps
module sad_master_port
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire sad_pkg::sad_req_s req,
   input wire sad_pkg::sad_size_e flash_size,
   input wire sad_pkg::sad_size_e sram_size,
   input wire sad_pkg::sad_remap_e remap,
   output sad_pkg::sad_route_s route,
   output logic route_valid
);

   logic [31:0] eff_addr;
   logic is_vec;
   sad_pkg::sad_target_e raw_target;
   sad_pkg::sad_target_e next_target;

   // ****************************************
   // Vector remap
   // ****************************************
   assign is_vec = sad_pkg::in_range(req.addr, sad_pkg::FLASH_BASE, sad_pkg::VEC_LAST);

   always_comb
   begin
      eff_addr = req.addr;
      if (is_vec)
      begin
         case (remap) // see RQ21
            sad_pkg::SAD_REMAP_BOOT: eff_addr = sad_pkg::BOOT_BASE | req.addr;
            sad_pkg::SAD_REMAP_SRAM: eff_addr = sad_pkg::SRAM_BASE | req.addr;
            sad_pkg::SAD_REMAP_PSRAM: eff_addr = sad_pkg::PSRAM0_BASE | req.addr;
            default: eff_addr = req.addr;
         endcase
      end
   end

   sad_region_decode u_dec
   (
      .addr(eff_addr),
      .flash_size(flash_size),
      .sram_size(sram_size),
      .target(raw_target)
   );

   assign next_target = raw_target;

   // ****************************************
   // Registered route, one per master
   // ****************************************
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         route <= '{target: sad_pkg::SAD_T_NONE, addr: 32'h0000_0000, slot: 7'h00,
                    error: 1'b0};
         route_valid <= 1'b0;
      end
      else
      begin
         route_valid <= req.valid;
         route.target <= next_target;
         route.addr <= eff_addr;
         // Slot index is address bits above the low fourteen
         route.slot <= eff_addr[sad_pkg::SLOT_LSB +: 7]; // see RQ11
         route.error <= req.valid && (next_target == sad_pkg::SAD_T_NONE); // see RQ23
      end
   end

endmodule

// ==== core/sad_decoder.sv ====
`timescale 1ns/1ps
// How it works
// RQ1: Flash decodes from zero up to a limit set by fitted flash size.
// RQ2: Main SRAM from 0x1000_0000, up to 0x1000_FFFF with 64 kB.
// RQ3: Boot ROM occupies 0x1FFF_0000 through 0x1FFF_1FFF.
// RQ4: Peripheral SRAM bank zero spans 0x2000_0000 to 0x2000_3FFF.
// RQ5: Peripheral SRAM bank one spans 0x2000_4000 to 0x2000_7FFF.
// RQ6: High-speed peripherals decode in 0x2008_0000 to 0x200B_FFFF.
// RQ7: High-speed area is 2 MB worth of slot space, 128 slots.
// RQ8: Low-speed bus zero covers 0x4000_0000 to 0x4007_FFFF, 32 blocks.
// RQ9: Low-speed bus one covers 0x4008_0000 to 0x400F_FFFF, 32 blocks.
// RQ10: Low-speed area is 1 MB, 64 slots across both buses.
// RQ11: Every slot is 16 kB, chosen by address bits above fourteen.
// RQ12: Static chip select zero for 0x8000_0000 to 0x83FF_FFFF.
// RQ13: Static chip select one for 0x9000_0000 to 0x93FF_FFFF.
// RQ14: Static chip select two for 0x9800_0000 to 0x9BFF_FFFF.
// RQ15: Static chip select three for 0x9C00_0000 to 0x9FFF_FFFF.
// RQ16: Dynamic chip select zero for 0xA000_0000 to 0xAFFF_FFFF.
// RQ17: Dynamic chip select one for 0xB000_0000 to 0xBFFF_FFFF.
// RQ18: Dynamic chip select two for 0xC000_0000 to 0xCFFF_FFFF.
// RQ19: Dynamic chip select three for 0xD000_0000 to 0xDFFF_FFFF.
// RQ20: 0xE000_0000 to 0xE00F_FFFF goes to the private peripheral bus.
// RQ21: Vector area fetches can be remapped to another memory.
// RQ22: Both masters decode independently and concurrently, never serialised.
// RQ23: Unmapped addresses return a bus error to the requester.
module sad_decoder
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire sad_pkg::sad_req_s cpu_req,
   input wire sad_pkg::sad_req_s dma_req,
   input wire sad_pkg::sad_size_e flash_size,
   input wire sad_pkg::sad_size_e sram_size,
   input wire sad_pkg::sad_remap_e vec_remap,
   output sad_pkg::sad_route_s cpu_route,
   output logic cpu_route_valid,
   output logic cpu_err,
   output sad_pkg::sad_route_s dma_route,
   output logic dma_route_valid,
   output logic dma_err,
   output logic [3:0] cpu_static_cs,
   output logic [3:0] cpu_dynamic_cs,
   output logic [3:0] dma_static_cs,
   output logic [3:0] dma_dynamic_cs,
   output logic [5:0] cpu_lsp_slot,
   output logic [6:0] cpu_hsp_slot,
   output logic [5:0] dma_lsp_slot,
   output logic [6:0] dma_hsp_slot,
   output logic conflict
);

   // ****************************************
   // Per-master decode paths
   // ****************************************
   // Two independent decoders so neither master waits on the other
   sad_master_port u_cpu // see RQ22
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req(cpu_req),
      .flash_size(flash_size),
      .sram_size(sram_size),
      .remap(vec_remap),
      .route(cpu_route),
      .route_valid(cpu_route_valid)
   );

   sad_master_port u_dma
   (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .req(dma_req),
      .flash_size(flash_size),
      .sram_size(sram_size),
      .remap(sad_pkg::SAD_REMAP_NONE),
      .route(dma_route),
      .route_valid(dma_route_valid)
   );

   // ****************************************
   // Chip selects and slot numbers
   // ****************************************
   function automatic logic [3:0] static_cs(input sad_pkg::sad_route_s r, input logic v);
      logic [3:0] cs;
      cs = 4'h0;
      if (v)
      begin
         cs[0] = (r.target == sad_pkg::SAD_T_SCS0); // see RQ12
         cs[1] = (r.target == sad_pkg::SAD_T_SCS1); // see RQ13
         cs[2] = (r.target == sad_pkg::SAD_T_SCS2); // see RQ14
         cs[3] = (r.target == sad_pkg::SAD_T_SCS3); // see RQ15
      end
      return cs;
   endfunction

   function automatic logic [3:0] dynamic_cs(input sad_pkg::sad_route_s r, input logic v);
      logic [3:0] cs;
      cs = 4'h0;
      if (v)
      begin
         cs[0] = (r.target == sad_pkg::SAD_T_DCS0); // see RQ16
         cs[1] = (r.target == sad_pkg::SAD_T_DCS1); // see RQ17
         cs[2] = (r.target == sad_pkg::SAD_T_DCS2); // see RQ18
         cs[3] = (r.target == sad_pkg::SAD_T_DCS3); // see RQ19
      end
      return cs;
   endfunction

   // Both low-speed buses share one 64-slot numbering
   function automatic logic [5:0] lsp_slot(input sad_pkg::sad_route_s r);
      return r.slot[5:0]; // see RQ10
   endfunction

   // High-speed slots: 128 of 16 kB, 2 MB of slot space
   function automatic logic [6:0] hsp_slot(input sad_pkg::sad_route_s r);
      return r.slot; // see RQ7
   endfunction

   assign cpu_static_cs = static_cs(cpu_route, cpu_route_valid);
   assign cpu_dynamic_cs = dynamic_cs(cpu_route, cpu_route_valid);
   assign dma_static_cs = static_cs(dma_route, dma_route_valid);
   assign dma_dynamic_cs = dynamic_cs(dma_route, dma_route_valid);
   assign cpu_lsp_slot = lsp_slot(cpu_route);
   assign cpu_hsp_slot = hsp_slot(cpu_route);
   assign dma_lsp_slot = lsp_slot(dma_route);
   assign dma_hsp_slot = hsp_slot(dma_route);

   assign cpu_err = cpu_route_valid && cpu_route.error; // see RQ23
   assign dma_err = dma_route_valid && dma_route.error;

   // Only same-slave traffic would need arbitration; flag it for the matrix
   assign conflict = cpu_route_valid && dma_route_valid && !cpu_route.error
                     && (cpu_route.target == dma_route.target);

endmodule

// ==== sim/sad_decoder_monitor.sv ====
`timescale 1ns/1ps
module sad_decoder_monitor
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire sad_pkg::sad_req_s cpu_req,
   input wire sad_pkg::sad_req_s dma_req,
   input wire sad_pkg::sad_route_s cpu_route,
   input wire logic cpu_route_valid,
   input wire logic cpu_err,
   input wire sad_pkg::sad_route_s dma_route,
   input wire logic dma_route_valid,
   input wire logic dma_err,
   input wire logic [3:0] cpu_static_cs,
   input wire logic [3:0] cpu_dynamic_cs,
   input wire logic [6:0] cpu_hsp_slot,
   input wire logic conflict
);
   // ****************************************
   // Route timing and selects
   // ****************************************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   sequence s_cpu_taken;
      cpu_req.valid ##1 cpu_route_valid;
   endsequence
   sequence s_scs1_req;
      cpu_req.valid && cpu_req.addr[31:26] == 6'h24;
   endsequence
   a_cpu_req_taken: assert property (cpu_req.valid |-> s_cpu_taken)
      else $error("cpu request not answered");
   a_cpu_no_spurious: assert property (!cpu_req.valid |=> !cpu_route_valid && !cpu_err
      && cpu_static_cs == 4'h0) else $error("cpu answer without request");
   a_dma_route_valid: assert property (dma_route_valid == $past(dma_req.valid))
      else $error("dma answer out of step");
   a_err_no_target: assert property (cpu_err |-> cpu_route_valid
      && cpu_route.target == sad_pkg::SAD_T_NONE) else $error("error with a target");
   a_scs1_select: assert property (s_scs1_req |=> cpu_static_cs == 4'h2
      && cpu_route.target == sad_pkg::SAD_T_SCS1) else $error("static select one wrong");
   a_dcs0_select: assert property (cpu_req.valid && cpu_req.addr[31:28] == 4'hA
      |=> cpu_dynamic_cs == 4'h1) else $error("dynamic select zero wrong");
   a_ppb_route: assert property (cpu_req.valid && cpu_req.addr[31:20] == 12'hE00
      |=> cpu_route.target == sad_pkg::SAD_T_PPB) else $error("private bus not routed");
   a_hsp_slot_bits: assert property (cpu_req.valid && cpu_req.addr[31:18] == 14'h0802
      |=> cpu_hsp_slot == $past(cpu_req.addr[20:14])) else $error("fast slot wrong");
   a_gap_error: assert property (cpu_req.valid && cpu_req.addr[31:24] == 8'h84
      |=> cpu_err && cpu_static_cs == 4'h0) else $error("gap not refused");
   a_conflict_flag: assert property (conflict == (cpu_route_valid && dma_route_valid
      && !cpu_err && !dma_err && cpu_route.target == dma_route.target))
      else $error("conflict flag wrong");
endmodule
bind sad_decoder sad_decoder_monitor u_mon (.core_clk, .rst_n, .cpu_req, .dma_req, .cpu_route,
   .cpu_route_valid, .cpu_err, .dma_route, .dma_route_valid, .dma_err, .cpu_static_cs,
   .cpu_dynamic_cs, .cpu_hsp_slot, .conflict);

// ==== sim/sad_bus_master.sv ====
`timescale 1ns/1ps
module sad_bus_master
(
   input wire logic core_clk,
   output sad_pkg::sad_req_s req
);
   // ****************************************
   // Request driver
   // ****************************************
   initial req = '0;
   // Masters run apart, never serialised
   task send(input logic [31:0] a);
      @(posedge core_clk);
      #1 req = {1'b1, 1'b0, a};
   endtask
   // Released lines invert, so a stale address cannot pass
   task idle();
      @(posedge core_clk);
      #1 req = {1'b0, ~req.write, ~req.addr};
   endtask
endmodule

// ==== sim/system_address_decoder_tb_top.sv ====
`timescale 1ns/1ps
module system_address_decoder_tb_top;
   // ****************************************
   // Bench signals
   // ****************************************
   logic core_clk, rst_n, cpu_route_valid, cpu_err, dma_route_valid, dma_err, conflict;
   sad_pkg::sad_req_s cpu_req, dma_req;
   sad_pkg::sad_size_e flash_size, sram_size;
   sad_pkg::sad_remap_e vec_remap;
   sad_pkg::sad_route_s cpu_route, dma_route;
   logic [3:0] cpu_static_cs, cpu_dynamic_cs, dma_static_cs, dma_dynamic_cs;
   logic [5:0] cpu_lsp_slot, dma_lsp_slot;
   logic [6:0] cpu_hsp_slot, dma_hsp_slot;
   int miscompares = 0;
   int check_count = 0;
   sad_decoder u_sad_decoder (.core_clk, .rst_n, .cpu_req, .dma_req, .flash_size, .sram_size,
      .vec_remap, .cpu_route, .cpu_route_valid, .cpu_err, .dma_route, .dma_route_valid, .dma_err,
      .cpu_static_cs, .cpu_dynamic_cs, .dma_static_cs, .dma_dynamic_cs, .cpu_lsp_slot,
      .cpu_hsp_slot, .dma_lsp_slot, .dma_hsp_slot, .conflict);
   sad_bus_master u_cpu (.core_clk, .req(cpu_req));
   sad_bus_master u_dma (.core_clk, .req(dma_req));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic sad_pkg::sad_target_e exp_t(input logic [31:0] a);
      if (a <= (32'h7FFFF >> flash_size)) return sad_pkg::SAD_T_FLASH;
      // Fitted SRAM shrinks from the top of its window, the base stays put
      if (a >= 32'h10000000 && a <= (32'h10000000 | (32'hFFFF >> ((sram_size > 2) ? 2 : sram_size))))
         return sad_pkg::SAD_T_SRAM;
      if (a[31:13] == 19'h0FFF8) return sad_pkg::SAD_T_BOOT;
      if (a[31:14] == 18'h08000) return sad_pkg::SAD_T_PSRAM0;
      if (a[31:14] == 18'h08001) return sad_pkg::SAD_T_PSRAM1;
      if (a[31:18] == 14'h0802) return sad_pkg::SAD_T_HSP;
      if (a[31:19] == 13'h0800) return sad_pkg::SAD_T_LSB0;
      if (a[31:19] == 13'h0801) return sad_pkg::SAD_T_LSB1;
      if (a[31:26] == 6'h20) return sad_pkg::SAD_T_SCS0;
      if (a[31:26] == 6'h24) return sad_pkg::SAD_T_SCS1;
      if (a[31:26] == 6'h26) return sad_pkg::SAD_T_SCS2;
      if (a[31:26] == 6'h27) return sad_pkg::SAD_T_SCS3;
      if (a[31:28] inside {[4'hA:4'hD]})
         return sad_pkg::sad_target_e'(sad_pkg::SAD_T_DCS0 + a[31:28] - 4'hA);
      if (a[31:20] == 12'hE00) return sad_pkg::SAD_T_PPB;
      return sad_pkg::SAD_T_NONE;
   endfunction
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic look(input sad_pkg::sad_target_e t);
      int d;
      d = t - sad_pkg::SAD_T_SCS0;
      cmp(cpu_route_valid, 1'b1);
      cmp(cpu_route.target, t);
      cmp(cpu_err, t == sad_pkg::SAD_T_NONE);
      cmp(cpu_static_cs, (d >= 0 && d < 4) ? 4'h1 << d : 4'h0);
      cmp(cpu_dynamic_cs, (d >= 4 && d < 8) ? 4'h1 << (d - 4) : 4'h0);
   endtask
   task automatic go(input logic [31:0] a);
      u_cpu.send(a);
      u_cpu.idle();
   endtask
   task automatic both(input logic [31:0] a, input logic [31:0] b);
      fork
         u_cpu.send(a);
         u_dma.send(b);
      join
      fork
         u_cpu.idle();
         u_dma.idle();
      join
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_map();
      logic [31:0] tab [$] = '{32'h0, 32'h7FFFF, 32'h80000, 32'h10000000, 32'h1000FFFF,
         32'h10010000, 32'h1FFF0000, 32'h1FFF1FFF, 32'h1FFF2000, 32'h20000000, 32'h20003FFF,
         32'h20004000, 32'h20007FFF, 32'h20008000, 32'h20080000, 32'h200BFFFF, 32'h200C0000,
         32'h40000000, 32'h4007FFFF, 32'h40080000, 32'h400FFFFF, 32'h40100000, 32'h80000000,
         32'h83FFFFFF, 32'h84000000, 32'h93FFFFFF, 32'h98000000, 32'h9BFFFFFF, 32'h9C000000,
         32'h9FFFFFFF, 32'hA0000000, 32'hAFFFFFFF, 32'hB0000000, 32'hC0000000, 32'hDFFFFFFF,
         32'hE0000000, 32'hE00FFFFF, 32'hE0100000};
      foreach (tab[i])
      begin
         u_cpu.send(tab[i]);
         if (i > 0) look(exp_t(tab[i - 1]));
      end
      u_cpu.idle();
      look(exp_t(tab[tab.size() - 1]));
      u_cpu.idle();
      cmp({cpu_route_valid, cpu_err, cpu_static_cs, cpu_dynamic_cs}, 0);
      $display("t_map done");
   endtask
   task automatic t_sizes();
      logic [31:0] a [4];
      for (int s = 0; s < 4; s++)
      begin
         flash_size = sad_pkg::sad_size_e'(s);
         sram_size = sad_pkg::sad_size_e'(s);
         a[0] = 32'h7FFFF >> s;
         a[1] = a[0] + 1;
         a[2] = 32'h10000000 | (32'hFFFF >> ((s > 2) ? 2 : s));
         a[3] = a[2] + 1;
         foreach (a[i])
         begin
            go(a[i]);
            look(exp_t(a[i]));
         end
      end
      flash_size = sad_pkg::SAD_SZ_LARGE;
      sram_size = sad_pkg::SAD_SZ_LARGE;
      $display("t_sizes done");
   endtask
   task automatic t_slots();
      for (int k = 0; k < 64; k++)
      begin
         both(32'h20080000 + (k % 16) * 32'h4000, 32'h40000000 + k * 32'h4000);
         cmp(cpu_hsp_slot, 32 + k % 16);
         cmp(cpu_lsp_slot, 32 + k % 16);
         cmp(dma_hsp_slot, k);
         cmp(dma_lsp_slot, k);
         cmp(dma_route.target, (k < 32) ? sad_pkg::SAD_T_LSB0 : sad_pkg::SAD_T_LSB1);
      end
      $display("t_slots done");
   endtask
   task automatic t_remap();
      logic [31:0] base [4] = '{32'h0, 32'h1FFF0000, 32'h10000000, 32'h20000000};
      sad_pkg::sad_target_e tg [4] = '{sad_pkg::SAD_T_FLASH, sad_pkg::SAD_T_BOOT,
         sad_pkg::SAD_T_SRAM, sad_pkg::SAD_T_PSRAM0};
      for (int r = 0; r < 4; r++)
      begin
         vec_remap = sad_pkg::sad_remap_e'(r);
         both(32'h10, 32'h10);
         cmp(cpu_route.target, tg[r]);
         cmp(cpu_route.addr, base[r] | 32'h10);
         cmp(dma_route.target, sad_pkg::SAD_T_FLASH);
         cmp(dma_route.addr, 32'h10);
         go(32'h40);
         look(sad_pkg::SAD_T_FLASH);
      end
      vec_remap = sad_pkg::SAD_REMAP_NONE;
      $display("t_remap done");
   endtask
   task automatic t_conc();
      logic [31:0] ca [5] = '{32'h40000000, 32'h10000000, 32'h84000000, 32'hA0000000,
         32'h9C000000};
      logic [31:0] da [5] = '{32'h40080000, 32'h10000004, 32'h84000000, 32'h9C000000,
         32'hB0000000};
      logic [7:0] dcs [5] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h02};
      for (int i = 0; i < 5; i++)
      begin
         both(ca[i], da[i]);
         cmp({cpu_route_valid, dma_route_valid, conflict}, {2'b11, i == 1});
         cmp(dma_err, i == 2);
         cmp({dma_static_cs, dma_dynamic_cs}, dcs[i]);
      end
      $display("t_conc done");
   endtask
   task automatic t_reset();
      u_cpu.send(32'h90000000);
      rst_n = 1'b0;
      u_cpu.idle();
      cmp({cpu_route_valid, conflict, cpu_static_cs}, 0);
      cmp(cpu_route.addr, 0);
      cmp(cpu_route.target, sad_pkg::SAD_T_NONE);
      u_cpu.idle();
      rst_n = 1'b1;
      go(32'h90000010);
      look(sad_pkg::SAD_T_SCS1);
      $display("t_reset done");
   endtask
   // ****************************************
   // Run control
   // ****************************************
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   // A hang ends the run as a mismatch
   initial
   begin
      repeat (20000) @(posedge core_clk);
      miscompares++;
      complete_run();
   end
   initial
   begin
      rst_n = 1'b0;
      flash_size = sad_pkg::SAD_SZ_LARGE;
      sram_size = sad_pkg::SAD_SZ_LARGE;
      vec_remap = sad_pkg::SAD_REMAP_NONE;
      repeat (12) @(posedge core_clk);
      #1 rst_n = 1'b1;
      t_map();
      t_sizes();
      t_slots();
      t_remap();
      t_conc();
      t_reset();
      complete_run();
   end
endmodule
